// ### design/i2c_slave_status_flags.sv
/*
 * status-flag logic of an i2c slave: start/repeated-start, id match,
 * stop-after-match, general-call classification and general-call reset.
 * assumes bus events arrive as synchronous one-cycle pulses and that
 * software uses a plain register port with read data one cycle later.
 */
// Our own choice: the address-and-strobe port.
// Operation
// - start flag on match, start byte, general call
// - stop clears start and repeated-start flags
// - repeated start sets repeated-start flag
// - status read clears repeated-start flag
// - bits 12:11 give matched id index
// - stop after matched start sets stop flag
// - stop flag raises interrupt when enabled
// - status read clears stop flag
// - general call type coded in bits 9:8
// - general call reset keeps type field
// - clear bit write clears type field
// - any general call sets general call flag
// - general call reset restores register defaults
// - hardware general call byte goes to fifo
// - 0x06 resets, 0x04 only flags reprogramming
// - alternate id match is hardware general call
// - clear bit write clears general call flag
module i2c_slave_status_flags #(
	parameter int ADDR_W = i2c_status_pkg::ADDR_W,
	parameter int DATA_W = i2c_status_pkg::DATA_W
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire i2c_status_pkg::bus_evt_t evt_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [DATA_W-1:0] reg_rdata_out,
	output logic stop_irq_out,
	output logic rx_push_out,
	output logic [7:0] rx_byte_out,
	output logic gc_reset_out
);
	localparam int N = i2c_status_pkg::NUM_IDS;

	logic start_q;
	logic reps_q;
	logic [1:0] id_q;
	logic stop_q;
	logic [1:0] gct_q;
	logic gc_q;
	logic matched_q;
	logic [7:0] ctrl_q;
	logic [6:0] id_reg_q [N];
	logic [7:0] alt_q;
	logic [DATA_W-1:0] rdata_q;
	logic rx_push_q;
	logic [7:0] rx_byte_q;
	logic gc_reset_q;
	i2c_status_pkg::gc_state_t gc_st_q;

	logic [15:0] status;
	logic [N-1:0] hit;
	logic any_hit;
	logic [1:0] hit_idx;
	logic gc_en;
	logic hwgc_en;
	logic gc_addr;
	logic start_byte;
	logic gc_byte;
	logic gc_rst_cmd;
	logic gc_prog_cmd;
	logic gc_alt_cmd;
	logic soft_rst;
	logic rd_status;
	logic wr_ctrl;
	logic gc_clr;

	assign gc_en = ctrl_q[i2c_status_pkg::CT_GC_EN_BIT];
	assign hwgc_en = ctrl_q[i2c_status_pkg::CT_HWGC_EN_BIT];
	assign rd_status = reg_rd_in && reg_addr_in == i2c_status_pkg::SLAVE_STATUS_OFS;
	assign wr_ctrl = reg_wr_in && reg_addr_in == i2c_status_pkg::SLAVE_CONTROL_OFS;
	assign gc_clr = wr_ctrl && reg_wdata_in[i2c_status_pkg::CT_GC_CLR_BIT];

	// address compare: 7-bit id against the upper bits of the address byte
	generate
		for (genvar i = 0; i < N; i++) begin : g_match
			assign hit[i] = evt_in.addr_valid && evt_in.rx_byte[7:1] == id_reg_q[i];
		end
	endgenerate

	always_comb begin
		hit_idx = 2'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (hit[i]) begin
				hit_idx = 2'(i);
			end
		end
	end

	assign any_hit = |hit;
	assign gc_addr = evt_in.addr_valid && gc_en && evt_in.rx_byte == i2c_status_pkg::GC_ADDR;
	assign start_byte = evt_in.addr_valid && evt_in.rx_byte == i2c_status_pkg::START_BYTE;
	assign gc_byte = evt_in.data_valid && gc_st_q == i2c_status_pkg::GC_WAIT;
	assign gc_rst_cmd = gc_byte && evt_in.rx_byte == i2c_status_pkg::GC_RESET_CMD;
	assign gc_prog_cmd = gc_byte && evt_in.rx_byte == i2c_status_pkg::GC_PROG_CMD;
	// hardware general call only with both enables and an alternate id hit
	assign gc_alt_cmd = gc_byte && hwgc_en && !gc_rst_cmd && !gc_prog_cmd
		&& evt_in.rx_byte == alt_q;
	assign soft_rst = gc_rst_cmd;

	// reserved bit and the lower flags left to other logic read zero
	assign status = {1'b0, start_q, reps_q, id_q, stop_q, gct_q, gc_q, 7'h00};

	// general call sequencing: address 0x00 then one command byte
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || soft_rst || evt_in.stop) begin
			gc_st_q <= i2c_status_pkg::GC_IDLE;
		end else if (gc_addr) begin
			gc_st_q <= i2c_status_pkg::GC_WAIT;
		end else if (evt_in.data_valid || evt_in.start || evt_in.rep_start) begin
			gc_st_q <= i2c_status_pkg::GC_IDLE;
		end
	end

	// start flag and id index
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || soft_rst) begin
			start_q <= 1'b0;
			id_q <= 2'h0;
			matched_q <= 1'b0;
		end else if (evt_in.stop) begin
			start_q <= 1'b0;
			matched_q <= 1'b0;
		end else if (any_hit || start_byte || gc_addr) begin
			start_q <= 1'b1;
			matched_q <= 1'b1;
			if (any_hit) begin
				id_q <= hit_idx;
			end
		end
	end

	// repeated start: the bus event beats a simultaneous read clear
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || soft_rst) begin
			reps_q <= 1'b0;
		end else if (evt_in.stop) begin
			reps_q <= 1'b0;
		end else if (evt_in.rep_start) begin
			reps_q <= 1'b1;
		end else if (rd_status) begin
			reps_q <= 1'b0;
		end
	end

	// stop after a matched start
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || soft_rst) begin
			stop_q <= 1'b0;
		end else if (evt_in.stop && matched_q) begin
			stop_q <= 1'b1;
		end else if (rd_status) begin
			stop_q <= 1'b0;
		end
	end

	// level interrupt: follows the flag while enabled, so reading clears it
	assign stop_irq_out = stop_q && ctrl_q[i2c_status_pkg::CT_STOP_IRQ_BIT];

	// type field survives the general call reset, only a clear write empties it
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			gct_q <= i2c_status_pkg::GCT_NONE;
		end else if (gc_rst_cmd) begin
			gct_q <= i2c_status_pkg::GCT_RESET;
		end else if (gc_prog_cmd) begin
			gct_q <= i2c_status_pkg::GCT_PROG;
		end else if (gc_alt_cmd) begin
			gct_q <= i2c_status_pkg::GCT_ALT;
		end else if (gc_clr) begin
			gct_q <= i2c_status_pkg::GCT_NONE;
		end
	end

	// general call flag; the command that resets still leaves it set
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			gc_q <= 1'b0;
		end else if (gc_byte) begin
			gc_q <= 1'b1;
		end else if (gc_clr || soft_rst) begin
			gc_q <= 1'b0;
		end
	end

	// second byte of a hardware general call pushed to the receive fifo
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rx_push_q <= 1'b0;
			rx_byte_q <= 8'h00;
			gc_reset_q <= 1'b0;
		end else begin
			rx_push_q <= gc_alt_cmd;
			gc_reset_q <= soft_rst;
			if (gc_alt_cmd) begin
				rx_byte_q <= evt_in.rx_byte;
			end
		end
	end

	assign rx_push_out = rx_push_q;
	assign rx_byte_out = rx_byte_q;
	assign gc_reset_out = gc_reset_q;

	// software registers; all return to default on a general call reset
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || soft_rst) begin
			ctrl_q <= i2c_status_pkg::CONTROL_RST;
			alt_q <= i2c_status_pkg::ALT_RST;
			for (int i = 0; i < N; i++) begin
				id_reg_q[i] <= i2c_status_pkg::ID_RST;
			end
		end else if (reg_wr_in) begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata_in[7:0] & i2c_status_pkg::CT_RW_MASK;
			end
			if (reg_addr_in == i2c_status_pkg::ALT_ID_OFS) begin
				alt_q <= reg_wdata_in[7:0];
			end
			for (int i = 0; i < N; i++) begin
				if (reg_addr_in == i2c_status_pkg::SLAVE_ID0_OFS + 32'(4 * i)) begin
					id_reg_q[i] <= reg_wdata_in[6:0];
				end
			end
		end
	end

	// read port: one cycle latency, unmapped addresses return zero
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rdata_q <= '0;
		end else if (reg_rd_in) begin
			rdata_q <= '0;
			if (rd_status) begin
				rdata_q <= DATA_W'(status);
			end else if (reg_addr_in == i2c_status_pkg::SLAVE_CONTROL_OFS) begin
				rdata_q <= DATA_W'(ctrl_q);
			end else if (reg_addr_in == i2c_status_pkg::ALT_ID_OFS) begin
				rdata_q <= DATA_W'(alt_q);
			end
			for (int i = 0; i < N; i++) begin
				if (reg_addr_in == i2c_status_pkg::SLAVE_ID0_OFS + 32'(4 * i)) begin
					rdata_q <= DATA_W'(id_reg_q[i]);
				end
			end
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata_out = rdata_q;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// the id check looks the index up in the id registers, so a broken encoder shows
	start_set_a: assert property ((any_hit || start_byte || gc_addr) && !evt_in.stop
		&& !soft_rst |=> start_q) else $error("start flag not set");
	stop_clears_a: assert property (evt_in.stop |=> !start_q && !reps_q)
		else $error("stop left start flags set");
	reps_set_a: assert property (evt_in.rep_start && !evt_in.stop && !soft_rst
		|=> reps_q) else $error("repeated start not flagged");
	read_clr_a: assert property (rd_status && !evt_in.rep_start
		&& !(evt_in.stop && matched_q) |=> !reps_q && !stop_q)
		else $error("read did not clear flags");
	id_index_a: assert property (any_hit && !evt_in.stop && !soft_rst && !reg_wr_in
		|=> id_reg_q[id_q] == $past(evt_in.rx_byte[7:1]))
		else $error("wrong id index");
	stop_match_a: assert property (evt_in.stop && matched_q && !soft_rst |=> stop_q)
		else $error("stop after match missing");
	irq_follow_a: assert property (evt_in.stop && matched_q && !soft_rst && !wr_ctrl
		&& ctrl_q[i2c_status_pkg::CT_STOP_IRQ_BIT] |=> stop_irq_out)
		else $error("interrupt not raised");
	gct_keep_a: assert property (gc_rst_cmd |=> gct_q == i2c_status_pkg::GCT_RESET
		&& gc_q && ctrl_q == i2c_status_pkg::CONTROL_RST)
		else $error("general call reset wrong");
	gc_clear_a: assert property (gc_clr && !gc_byte
		|=> !gc_q && gct_q == i2c_status_pkg::GCT_NONE) else $error("clear write ignored");
	hwgc_push_a: assert property (gc_alt_cmd |=> rx_push_out
		&& rx_byte_out == $past(alt_q)) else $error("hardware call byte not pushed");
	reserved_a: assert property (rd_status |=> reg_rdata_out[15] == 1'b0)
		else $error("reserved bit set");
	gc_flag_a: assert property (gc_byte |=> gc_q)
		else $error("general call flag not set");
	prog_type_a: assert property (gc_prog_cmd |=> gct_q == i2c_status_pkg::GCT_PROG
		&& !gc_reset_out) else $error("program command misread");
	gc_reset_a: assert property (gc_rst_cmd |=> gc_reset_out && !start_q && !reps_q
		&& !stop_q) else $error("general call reset incomplete");

	gc_reset_c: cover property (gc_rst_cmd);
	hw_call_c: cover property (gc_alt_cmd);
	match_stop_c: cover property (any_hit ##[1:50] evt_in.stop);
	reps_read_c: cover property (reps_q && rd_status);
	gc_prog_c: cover property (gc_prog_cmd);
endmodule

// ### shared/i2c_status_pkg.sv
/*
 * shared constants and carriers for the i2c slave status-flag block.
 * assumes a front end that turns scl/sda activity into one-cycle event pulses.
 */
package i2c_status_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int NUM_IDS = 4;
	localparam logic [31:0] SLAVE_STATUS_OFS = 32'hffff092c;
	localparam logic [31:0] SLAVE_CONTROL_OFS = 32'hffff0928;
	localparam logic [31:0] ALT_ID_OFS = 32'hffff0930;
	localparam logic [31:0] SLAVE_ID0_OFS = 32'hffff0940;
	localparam logic [15:0] SLAVE_STATUS_RST = 16'h0000;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [6:0] ID_RST = 7'h00;
	localparam logic [7:0] ALT_RST = 8'h00;
	// status bit positions
	localparam int ST_START_BIT = 14;
	localparam int ST_REPS_BIT = 13;
	localparam int ST_ID_LSB = 11;
	localparam int ST_STOP_BIT = 10;
	localparam int ST_GCT_LSB = 8;
	localparam int ST_GC_BIT = 7;
	// control bit positions
	localparam int CT_GC_EN_BIT = 2;
	localparam int CT_HWGC_EN_BIT = 3;
	localparam int CT_STOP_IRQ_BIT = 4;
	localparam int CT_GC_CLR_BIT = 5;
	localparam logic [7:0] CT_RW_MASK = 8'h1c;
	// special bytes on the bus
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [7:0] START_BYTE = 8'h01;
	localparam logic [7:0] GC_RESET_CMD = 8'h06;
	localparam logic [7:0] GC_PROG_CMD = 8'h04;
	// general call type codes
	localparam logic [1:0] GCT_NONE = 2'h0;
	localparam logic [1:0] GCT_RESET = 2'h1;
	localparam logic [1:0] GCT_PROG = 2'h2;
	localparam logic [1:0] GCT_ALT = 2'h3;

	typedef struct packed {
		logic start;
		logic rep_start;
		logic stop;
		logic addr_valid;
		logic data_valid;
		logic [7:0] rx_byte;
	} bus_evt_t;

	typedef enum logic [1:0] {
		GC_IDLE = 2'b01,
		GC_WAIT = 2'b10
	} gc_state_t;
endpackage

// ### dv/i2c_master_model.sv
/*
 * behavioural i2c bus master, seen as the event pulses of the front end.
 * assumes the caller keeps the legal order: start, address, data, stop.
 */
module i2c_master_model (
	input wire logic clk_in,
	output i2c_status_pkg::bus_evt_t evt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial evt_out = '0;
	// kind bits: start, rep_start, stop, addr_valid, data_valid
	task automatic send(input logic [4:0] kind, input logic [7:0] b);
		@(posedge clk_in);
		evt_out <= {kind, b};
		@(posedge clk_in);
		// released byte shows its inverse so a stale value never looks valid
		evt_out <= {5'h00, ~b};
	endtask
endmodule

// ### dv/i2c_slave_status_flags_bench.sv
/*
 * self-checking bench for the i2c slave status-flag block.
 * assumes the master model above and the register port of the block.
 */
module i2c_slave_status_flags_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] ST = i2c_status_pkg::SLAVE_STATUS_OFS;
	localparam logic [31:0] CT = i2c_status_pkg::SLAVE_CONTROL_OFS;
	localparam logic [31:0] ID0 = i2c_status_pkg::SLAVE_ID0_OFS;
	localparam logic [4:0] KS = 5'h10, KR = 5'h08, KP = 5'h04, KA = 5'h02, KD = 5'h01;
	logic clk_in, rst_n_in, reg_wr_in, reg_rd_in, stop_irq_out, rx_push_out, gc_reset_out;
	logic [31:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic [7:0] rx_byte_out, pushed;
	i2c_status_pkg::bus_evt_t evt_in;
	int err_total = 0, total_checks = 0, pushes = 0, resets = 0;

	i2c_slave_status_flags i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .evt_in(evt_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .stop_irq_out(stop_irq_out),
		.rx_push_out(rx_push_out), .rx_byte_out(rx_byte_out), .gc_reset_out(gc_reset_out));
	i2c_master_model i_master (.clk_in(clk_in), .evt_out(evt_in));

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// pulses are counted here since they stand for one cycle only
	always @(posedge clk_in) begin
		if (rx_push_out === 1'b1) begin
			pushes++;
			pushed = rx_byte_out;
		end
		if (gc_reset_out === 1'b1) resets++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out & m, exp);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// about 150 cycles are expected; this span of 4000 cycles is over twenty times that
	initial begin
		#20000;
		err_total++;
		end_sim();
	end

	initial begin
		rst_n_in = 1'b0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = '0;
		reg_wdata_in = '0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd(ST, 32'h0);
		wr(ST, 32'hffff);
		rd(ST, 32'h0);
		rd(32'hffff0ff0, 32'h0);
		for (int i = 0; i < 4; i++) wr(ID0 + 32'(4 * i), 32'h10 + 32'(i));
		for (int i = 0; i < 4; i++) begin
			i_master.send(KS, 8'h00);
			i_master.send(KA, 8'(8'h20 + 2 * i));
			rd(ST, 32'h4000 | (32'(i) << 11));
			i_master.send(KP, 8'h00);
			rd(ST, 32'h0400, 32'h6400);
			rd(ST, 32'h0, 32'h0400);
		end
		i_master.send(KS, 8'h00);
		i_master.send(KA, 8'h20);
		i_master.send(KR, 8'h00);
		rd(ST, 32'h6000, 32'h6000);
		rd(ST, 32'h4000, 32'h6000);
		i_master.send(KR, 8'h00);
		i_master.send(KP, 8'h00);
		rd(ST, 32'h0400, 32'h6400);
		i_master.send(KS, 8'h00);
		i_master.send(KA, i2c_status_pkg::START_BYTE);
		rd(ST, 32'h4000, 32'h4000);
		i_master.send(KP, 8'h00);
		rd(ST, 32'h0, 32'h4000);
		wr(CT, 32'h10);
		i_master.send(KS, 8'h00);
		i_master.send(KA, 8'h20);
		chk(32'(stop_irq_out), 32'h0);
		i_master.send(KP, 8'h00);
		#1 chk(32'(stop_irq_out), 32'h1);
		rd(ST, 32'h0400, 32'h0400);
		chk(32'(stop_irq_out), 32'h0);
		wr(CT, 32'h04);
		i_master.send(KS, 8'h00);
		i_master.send(KA, i2c_status_pkg::GC_ADDR);
		rd(ST, 32'h4000, 32'h4000);
		i_master.send(KD, i2c_status_pkg::GC_PROG_CMD);
		rd(ST, 32'h0280, 32'h0380);
		chk(32'(resets), 32'h0);
		i_master.send(KP, 8'h00);
		wr(CT, 32'h24);
		rd(ST, 32'h0, 32'h0380);
		// type is 10 before the reset command, 01 after it; a command pairs with its own address
		wr(CT, 32'h04);
		i_master.send(KS, 8'h00);
		i_master.send(KA, i2c_status_pkg::GC_ADDR);
		i_master.send(KD, i2c_status_pkg::GC_PROG_CMD);
		i_master.send(KR, 8'h00);
		i_master.send(KA, i2c_status_pkg::GC_ADDR);
		i_master.send(KD, i2c_status_pkg::GC_RESET_CMD);
		rd(ST, 32'h0180);
		chk(32'(resets), 32'h1);
		rd(CT, 32'h0);
		rd(ID0, 32'h0);
		wr(CT, 32'h2c);
		wr(i2c_status_pkg::ALT_ID_OFS, 32'h55);
		i_master.send(KS, 8'h00);
		i_master.send(KA, i2c_status_pkg::GC_ADDR);
		i_master.send(KD, 8'h55);
		rd(ST, 32'h0380, 32'h0380);
		chk(32'(pushes), 32'h1);
		chk(32'(pushed), 32'h55);
		i_master.send(KP, 8'h00);
		end_sim();
	end
endmodule
